// [design/gpm_cfg.svh]
/*
 * offsets, reset values and constants for the gpio pull-up,
 * function select and output write mask slice.
 * assumes inclusion by bare name from the package and design modules.
 */
`ifndef GPM_CFG_SVH
`define GPM_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define GPM_OFF_PULL_UP_DISABLE 12'h000
`define GPM_OFF_PULL_UP_ENABLE 12'h004
`define GPM_OFF_PULL_UP_STATUS 12'h008
`define GPM_OFF_FUNCTION_A_SELECT 12'h00C
`define GPM_OFF_FUNCTION_B_SELECT 12'h010
`define GPM_OFF_FUNCTION_SELECT_STATUS 12'h014
`define GPM_OFF_OUTPUT_WRITE_MASK_SET 12'h018
`define GPM_OFF_OUTPUT_WRITE_MASK_CLEAR 12'h01C
`define GPM_OFF_OUTPUT_WRITE_MASK_STATUS 12'h020
`define GPM_OFF_OUTPUT_DATA_STATUS 12'h024

// ----------------------------------------
// reset values
// ----------------------------------------
`define GPM_RST_PULL_UP_ON 32'hFFFF_FFFF
`define GPM_RST_FUNC_B 32'h0000_0000
`define GPM_RST_WRITE_MASK 32'h0000_0000
`define GPM_RST_OUTPUT_DATA 32'h0000_0000

// ----------------------------------------
// bus answers, address width and line count
// ----------------------------------------
`define GPM_RESP_OKAY 2'h0
`define GPM_RESP_SLVERR 2'h2
`define GPM_ADDR_W 12
`define GPM_LINES 32

`endif

// [design/gpm_pkg.sv]
/*
 * types for the gpio pull-up, function select and write mask slice.
 * assumes gpm_cfg.svh is on the include path.
 */
`include "gpm_cfg.svh"

package gpm_pkg;

	// ----------------------------------------
	// decoded register write
	// ----------------------------------------
	typedef struct packed {
		logic pu_dis;
		logic pu_en;
		logic fa_sel;
		logic fb_sel;
		logic wm_set;
		logic wm_clr;
		logic od_wr;
	} gpm_wsel_t;

	// ----------------------------------------
	// line state: the three words seen by the pad side plus the write mask
	// ----------------------------------------
	typedef struct packed {
		logic [`GPM_LINES-1:0] pull_up_on;
		logic [`GPM_LINES-1:0] func_b;
		logic [`GPM_LINES-1:0] write_mask;
		logic [`GPM_LINES-1:0] out_data;
	} gpm_lines_t;

	typedef enum logic [2:0] {
		GPM_W_IDLE = 3'b001,
		GPM_W_RESP = 3'b010,
		GPM_W_WAIT = 3'b100
	} gpm_wstate_t;

endpackage

// [design/gpm_setclr.sv]
/*
 * one stored bit per line, set by one strobe word and cleared by another.
 * assumes strobes and data come from the same clock domain.
 */
`timescale 1ns/1ns

module gpm_setclr
	import gpm_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// strobes
	input wire logic set_i,
	input wire logic clr_i,
	input wire logic [WIDTH-1:0] data_i,
	// stored bits
	output logic [WIDTH-1:0] q_o
);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_o <= RESET_VAL;
		end else if (set_i) begin
			q_o <= q_o | data_i;
		end else if (clr_i) begin
			q_o <= q_o & ~data_i;
		end
	end

	chk_set_sticks: assert property (@(posedge clk_i) disable iff (rst_i)
		(set_i ##1 !clr_i) |=> ((q_o & $past(data_i, 2)) == $past(data_i, 2)))
		else $error("set bit did not stick");

endmodule

// [design/gpm_wdata_mux.sv]
/*
 * masked update of the output data word from a direct write.
 * assumes purely combinational use inside the top module.
 */
`timescale 1ns/1ns

module gpm_wdata_mux
	import gpm_pkg::*;
#(
	parameter int WIDTH = 32
) (
	// operands
	input wire logic [WIDTH-1:0] cur_i,
	input wire logic [WIDTH-1:0] wdata_i,
	input wire logic [WIDTH-1:0] mask_i,
	input wire logic [3:0] strb_i,
	// result
	output logic [WIDTH-1:0] next_o
);

	logic [WIDTH-1:0] lane;

	always_comb begin
		lane = '0;
		for (int i = 0; i < WIDTH; i++) begin
			lane[i] = strb_i[i/8];
		end
	end

	assign next_o = (cur_i & ~(mask_i & lane)) | (wdata_i & mask_i & lane);

endmodule

// [design/gpm_top.sv]
/*
 * gpio pull-up control, function a/b select and output write mask slice,
 * with an axi4-lite register slave.
 * assumes a single clock, synchronous active-high reset and a master that
 * keeps valid and payload stable until taken.
 */
`timescale 1ns/1ns
`include "gpm_cfg.svh"

module gpm_top
	import gpm_pkg::*;
#(
	parameter int LINES = `GPM_LINES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// axi4-lite write address
	input wire logic [`GPM_ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// axi4-lite read address
	input wire logic [`GPM_ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// pad side
	output logic [LINES-1:0] pull_up_on_o,
	output logic [LINES-1:0] func_b_sel_o,
	output logic [LINES-1:0] line_bits_o
);

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic gpm_wsel_t wdecode(input logic [`GPM_ADDR_W-1:0] a);
		gpm_wsel_t s;
		s = '0;
		unique case ({a[`GPM_ADDR_W-1:2], 2'b00})
			`GPM_OFF_PULL_UP_DISABLE: s.pu_dis = 1'b1;
			`GPM_OFF_PULL_UP_ENABLE: s.pu_en = 1'b1;
			`GPM_OFF_FUNCTION_A_SELECT: s.fa_sel = 1'b1;
			`GPM_OFF_FUNCTION_B_SELECT: s.fb_sel = 1'b1;
			`GPM_OFF_OUTPUT_WRITE_MASK_SET: s.wm_set = 1'b1;
			`GPM_OFF_OUTPUT_WRITE_MASK_CLEAR: s.wm_clr = 1'b1;
			`GPM_OFF_OUTPUT_DATA_STATUS: s.od_wr = 1'b1;
			default: s = '0;
		endcase
		return s;
	endfunction

	function automatic logic full_word(input logic [3:0] st);
		return st == 4'hF;
	endfunction

	// ----------------------------------------
	// write channel
	// ----------------------------------------
	gpm_wstate_t wstate;
	logic aw_held;
	logic w_held;
	logic [`GPM_ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_go;
	gpm_wsel_t wsel;
	logic wr_ok;
	logic [LINES-1:0] wdat;

	assign s_axi_awready_o = (wstate == GPM_W_IDLE) && !aw_held;
	assign s_axi_wready_o = (wstate == GPM_W_IDLE) && !w_held;
	assign wr_go = (wstate == GPM_W_IDLE) && (aw_held || s_axi_awvalid_i) && (w_held || s_axi_wvalid_i);

	logic [`GPM_ADDR_W-1:0] cur_awaddr;
	logic [31:0] cur_wdata;
	logic [3:0] cur_wstrb;
	assign cur_awaddr = aw_held ? aw_addr : s_axi_awaddr_i;
	assign cur_wdata = w_held ? w_data : s_axi_wdata_i;
	assign cur_wstrb = w_held ? w_strb : s_axi_wstrb_i;
	assign wsel = wr_go ? wdecode(cur_awaddr) : '0;
	assign wdat = cur_wdata[LINES-1:0];
	// set/clear registers act only on a full word; output data honours strobes
	assign wr_ok = (wsel.od_wr) || full_word(cur_wstrb);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else if (wr_go) begin
			aw_held <= 1'b0;
		end else if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end else if (wr_go) begin
			w_held <= 1'b0;
		end else if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata_i;
			w_strb <= s_axi_wstrb_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wstate <= GPM_W_IDLE;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `GPM_RESP_OKAY;
		end else begin
			unique case (wstate)
				GPM_W_IDLE: begin
					if (wr_go) begin
						wstate <= GPM_W_RESP;
						s_axi_bvalid_o <= 1'b1;
						s_axi_bresp_o <= (wdecode(cur_awaddr) != '0) ? `GPM_RESP_OKAY : `GPM_RESP_SLVERR;
					end
				end
				GPM_W_RESP: begin
					if (s_axi_bready_i) begin
						wstate <= GPM_W_IDLE;
						s_axi_bvalid_o <= 1'b0;
					end
				end
				GPM_W_WAIT: begin
					wstate <= GPM_W_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// line state
	// ----------------------------------------
	logic [LINES-1:0] pull_up_on;
	logic [LINES-1:0] func_b;
	logic [LINES-1:0] write_mask;
	logic [LINES-1:0] out_data;
	logic [LINES-1:0] next_out_data;

	gpm_setclr #(.WIDTH(LINES), .RESET_VAL(`GPM_RST_PULL_UP_ON)) u_pull_up (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.set_i(wsel.pu_en && wr_ok),
		.clr_i(wsel.pu_dis && wr_ok),
		.data_i(wdat),
		.q_o(pull_up_on)
	);

	// function b set, function a clear
	gpm_setclr #(.WIDTH(LINES), .RESET_VAL(`GPM_RST_FUNC_B)) u_func_sel (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.set_i(wsel.fb_sel && wr_ok),
		.clr_i(wsel.fa_sel && wr_ok),
		.data_i(wdat),
		.q_o(func_b)
	);

	gpm_setclr #(.WIDTH(LINES), .RESET_VAL(`GPM_RST_WRITE_MASK)) u_write_mask (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.set_i(wsel.wm_set && wr_ok),
		.clr_i(wsel.wm_clr && wr_ok),
		.data_i(wdat),
		.q_o(write_mask)
	);

	gpm_wdata_mux #(.WIDTH(LINES)) u_wdata_mux (
		.cur_i(out_data),
		.wdata_i(wdat),
		.mask_i(write_mask),
		.strb_i(cur_wstrb),
		.next_o(next_out_data)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_data <= `GPM_RST_OUTPUT_DATA;
		end else if (wsel.od_wr) begin
			out_data <= next_out_data;
		end
	end

	assign pull_up_on_o = pull_up_on;
	assign func_b_sel_o = func_b;
	assign line_bits_o = out_data;

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	logic [31:0] rd_word;
	logic rd_hit;

	always_comb begin
		rd_word = '0;
		rd_hit = 1'b1;
		unique case ({s_axi_araddr_i[`GPM_ADDR_W-1:2], 2'b00})
			`GPM_OFF_PULL_UP_STATUS: rd_word[LINES-1:0] = ~pull_up_on;
			`GPM_OFF_FUNCTION_SELECT_STATUS: rd_word[LINES-1:0] = func_b;
			`GPM_OFF_OUTPUT_WRITE_MASK_STATUS: rd_word[LINES-1:0] = write_mask;
			`GPM_OFF_OUTPUT_DATA_STATUS: rd_word[LINES-1:0] = out_data;
			default: rd_hit = 1'b0;
		endcase
	end

	assign s_axi_arready_o = !s_axi_rvalid_o;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= '0;
			s_axi_rresp_o <= `GPM_RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o <= rd_word;
			s_axi_rresp_o <= rd_hit ? `GPM_RESP_OKAY : `GPM_RESP_SLVERR;
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_full_write;
		wr_go && full_word(cur_wstrb);
	endsequence

	chk_pullup_disable_off: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_full_write and wsel.pu_dis) |=> ((pull_up_on & $past(wdat)) == '0))
		else $error("pull-up disable left line on");

	chk_pullup_enable_on: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_full_write and wsel.pu_en) |=> ((pull_up_on & $past(wdat)) == $past(wdat)))
		else $error("pull-up enable left line off");

	chk_pullup_zero_noeffect: assert property (@(posedge clk_i) disable iff (rst_i)
		(wsel.pu_en) |=> ((pull_up_on & ~$past(wdat)) == ($past(pull_up_on) & ~$past(wdat))))
		else $error("zero bit changed pull-up");

	chk_pullup_status_inv: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == `GPM_OFF_PULL_UP_STATUS)
		|=> (s_axi_rvalid_o && s_axi_rdata_o[LINES-1:0] == ~$past(pull_up_on)))
		else $error("pull-up status not inverted");

	chk_func_a_route: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_full_write and wsel.fa_sel) |=> ((func_b & $past(wdat)) == '0))
		else $error("function a select failed");

	chk_func_b_route: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_full_write and wsel.fb_sel) |=> ((func_b & $past(wdat)) == $past(wdat)))
		else $error("function b select failed");

	chk_func_status_read: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == `GPM_OFF_FUNCTION_SELECT_STATUS)
		|=> (s_axi_rdata_o[LINES-1:0] == $past(func_b)))
		else $error("function status mismatch");

	chk_mask_blocks_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(wsel.od_wr) |=> ((out_data & ~$past(write_mask)) == ($past(out_data) & ~$past(write_mask))))
		else $error("masked line changed");

	chk_mask_passes_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(wsel.od_wr && full_word(cur_wstrb)) |=> ((out_data & $past(write_mask)) == ($past(wdat) & $past(write_mask))))
		else $error("enabled line ignored write");

	chk_mask_status_read: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == `GPM_OFF_OUTPUT_WRITE_MASK_STATUS)
		|=> (s_axi_rdata_o[LINES-1:0] == $past(write_mask)))
		else $error("write mask status mismatch");

	chk_line_level: assert property (@(posedge clk_i) disable iff (rst_i)
		!wsel.od_wr |=> $stable(line_bits_o))
		else $error("line level moved without write");

endmodule

// [sim/gpm_pad_model.sv]
/*
 * far side of the slice: pad ring and the two peripheral functions.
 * assumes the controller's pad outputs are registered and settled.
 */
`timescale 1ns/1ns

module gpm_pad_model (
	// controller side
	input wire logic [31:0] pull_up_on_i,
	input wire logic [31:0] func_b_sel_i,
	input wire logic [31:0] line_bits_i,
	// peripheral side
	output logic [31:0] periph_a_en_o,
	output logic [31:0] periph_b_en_o,
	output logic [31:0] pin_level_o,
	// weak level of an undriven pad
	output logic [31:0] pull_level_o
);
	assign periph_a_en_o = ~func_b_sel_i;
	assign periph_b_en_o = func_b_sel_i;
	assign pin_level_o = line_bits_i;
	// pulled high only with pull-up on
	assign pull_level_o = pull_up_on_i;
endmodule

// [sim/gpm_top_tb.sv]
/*
 * self-checking bench for the pull-up, function select and write mask slice.
 * assumes gpm_cfg.svh on the include path and the design sources compiled first.
 */
`timescale 1ns/1ns
`include "gpm_cfg.svh"

module gpm_top_tb;
	logic clk_i, rst_i, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, pu_o, fb_o, lb_o, pa, pb, pin, pl;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [31:0] pu, fb, wm, od;
	int errors, checks_done;

	gpm_top i_dut (
		.clk_i(clk_i), .rst_i(rst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.pull_up_on_o(pu_o), .func_b_sel_o(fb_o), .line_bits_o(lb_o)
	);

	gpm_pad_model i_pad (
		.pull_up_on_i(pu_o), .func_b_sel_i(fb_o), .line_bits_i(lb_o),
		.periph_a_en_o(pa), .periph_b_en_o(pb), .pin_level_o(pin), .pull_level_o(pl)
	);

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ----------------------------------------
	// axi4-lite master
	// ----------------------------------------
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		logic ta, tw, tb;
		tb = 1'b0;
		@(posedge clk_i);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!tb) begin
			@(negedge clk_i);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid && bready;
			r = bresp;
			@(posedge clk_i);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
		end
	endtask

	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		tr = 1'b0;
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!tr) begin
			@(negedge clk_i);
			ta = arvalid && arready;
			tr = rvalid && rready;
			d = rdata;
			r = rresp;
			@(posedge clk_i);
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
		end
	endtask

	// ----------------------------------------
	// reference model
	// ----------------------------------------
	task automatic do_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] bm;
		logic [1:0] r, er;
		bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		er = `GPM_RESP_OKAY;
		case (a)
			`GPM_OFF_PULL_UP_DISABLE: if (s == 4'hF) pu = pu & ~d;
			`GPM_OFF_PULL_UP_ENABLE: if (s == 4'hF) pu = pu | d;
			`GPM_OFF_FUNCTION_A_SELECT: if (s == 4'hF) fb = fb & ~d;
			`GPM_OFF_FUNCTION_B_SELECT: if (s == 4'hF) fb = fb | d;
			`GPM_OFF_OUTPUT_WRITE_MASK_SET: if (s == 4'hF) wm = wm | d;
			`GPM_OFF_OUTPUT_WRITE_MASK_CLEAR: if (s == 4'hF) wm = wm & ~d;
			`GPM_OFF_OUTPUT_DATA_STATUS: od = (od & ~(wm & bm)) | (d & wm & bm);
			default: er = `GPM_RESP_SLVERR;
		endcase
		axi_wr(a, d, s, r);
		chk({30'h0, r}, {30'h0, er});
		chk(pu_o, pu);
		chk(pl, pu);
		chk(fb_o, fb);
		chk(pin, od);
		chk(pa, ~fb);
		chk(pb, fb);
	endtask

	task automatic do_rd(input logic [11:0] a);
		logic [31:0] d, ed;
		logic [1:0] r, er;
		er = `GPM_RESP_OKAY;
		case (a)
			`GPM_OFF_PULL_UP_STATUS: ed = ~pu;
			`GPM_OFF_FUNCTION_SELECT_STATUS: ed = fb;
			`GPM_OFF_OUTPUT_WRITE_MASK_STATUS: ed = wm;
			`GPM_OFF_OUTPUT_DATA_STATUS: ed = od;
			default: begin
				ed = 32'h0000_0000;
				er = `GPM_RESP_SLVERR;
			end
		endcase
		axi_rd(a, d, r);
		chk(d, ed);
		chk({30'h0, r}, {30'h0, er});
	endtask

	task automatic rd_all;
		do_rd(`GPM_OFF_PULL_UP_STATUS);
		do_rd(`GPM_OFF_FUNCTION_SELECT_STATUS);
		do_rd(`GPM_OFF_OUTPUT_WRITE_MASK_STATUS);
		do_rd(`GPM_OFF_OUTPUT_DATA_STATUS);
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		test_done;
	end

	initial begin
		logic [11:0] ta[8];
		logic [31:0] td[8];
		logic [11:0] a;
		ta = '{12'h018, 12'h024, 12'h01C, 12'h024, 12'h000, 12'h004, 12'h010, 12'h00C};
		td = '{32'h0000_FFFF, 32'hFFFF_FFFF, 32'h0000_00FF, 32'h0000_0000,
			32'hF0F0_F0F0, 32'h3000_0000, 32'hAAAA_AAAA, 32'h0000_000A};
		rst_i = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		pu = `GPM_RST_PULL_UP_ON;
		fb = `GPM_RST_FUNC_B;
		wm = `GPM_RST_WRITE_MASK;
		od = `GPM_RST_OUTPUT_DATA;
		errors = 0;
		checks_done = 0;
		void'($urandom(1408));
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_all;
		chk(pu_o, pu);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			do_wr(ta[i], td[i], 4'hF);
			rd_all;
		end
		$display("test directed done");
		for (int i = 0; i < 300; i++) begin
			a = 12'($urandom_range(0, 11) * 4);
			if ($urandom_range(0, 2) == 0)
				do_rd(a);
			else
				do_wr(a, $urandom, ($urandom_range(0, 1) != 0) ? 4'hF : 4'($urandom));
		end
		rd_all;
		$display("test random done");
		// second reset from a busy state, bus idle
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		pu = `GPM_RST_PULL_UP_ON;
		fb = `GPM_RST_FUNC_B;
		wm = `GPM_RST_WRITE_MASK;
		od = `GPM_RST_OUTPUT_DATA;
		rd_all;
		chk(pu_o, pu);
		chk(fb_o, fb);
		chk(pin, od);
		$display("test second reset done");
		test_done;
	end
endmodule
